// File: verilog/pslb_top.sv
// Strap capture, isolate, indicators, duplex reporting, loopback, self test.
// Operation
// - Strapped address latches into transceiver_control[4:0] four cycles after reset release.
// - Address bit 0 from COL pin, bits 1-4 from receive data 0-3.
// - Strapped address 0 isolates; a written address 0 does not.
// - Unstrapped address defaults to 00001.
// - Setting basic_mode_control bit 10 also isolates.
// - Isolate ignores transmit inputs and floats the MII outputs.
// - Management access continues while isolated.
// - Isolated line side sends idles only; link bring-up continues.
// - Bits [6:5] select indicator mode 1, 2 or 3.
// - Mode 1 link indicator shows good link only.
// - Modes 2 and 3 link indicator on for link, blinks for activity.
// - Speed indicator on at 100 Mb/s, off at 10 Mb/s.
// - Third indicator shows activity, collision or full duplex by mode.
// - Each indicator polarity follows its sampled strap level.
// - Override register drives indicators; reads return register, not pins.
// - Full duplex: no collision, carrier from receive only.
// - Parallel detection always resolves to half duplex.
// - Loopback bit routes transmit to receive; status bit 3 reports it.
// - Self test sends 9 or 15 bit sequence; receiver compares locally.
// - Pass bit resets 0, sets on match, clears on miscompare and stays clear until start.
// - Diagnostic bit 5 selects continuous mode; bits [15:8] count errors.
`timescale 1ns/1ps
`default_nettype none
`include "pslb_consts.svh"
module pslb_top
  import pslb_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  // Management register port.
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Line-side status from the analog front end.
  input wire logic link_good_i,
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic par_detect_i,
  input wire logic line_rx_act_i,
  input wire logic line_col_i,
  input wire logic [3:0] line_rxd_i,
  input wire logic line_rx_dv_i,
  // MII transmit side.
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  // Shared receive/strap pins.
  input wire logic col_pin_i,
  input wire logic [3:0] rxd_pin_i,
  input wire logic [2:0] led_pin_i,
  output logic [3:0] rxd_o,
  output logic [3:0] rxd_oe_o,
  output logic rx_dv_o,
  output logic col_o,
  output logic crs_o,
  output logic mii_oe_o,
  output logic col_oe_o,
  // Line transmit.
  output logic line_tx_en_o,
  output logic [3:0] line_txd_o,
  output logic line_eff_fd_o,
  // Indicators: 0 link, 1 speed, 2 activity/collision/full duplex.
  output logic [2:0] led_o,
  output logic [2:0] led_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] strap_async;
  logic [4:0] strap_s;
  logic [2:0] led_s;
  assign strap_async = {rxd_pin_i, col_pin_i};
  pslb_sync #(.W(5)) u_sync_ad (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .d_i(strap_async),
    .q_o(strap_s)
  );
  pslb_sync #(.W(3)) u_sync_led (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .d_i(led_pin_i),
    .q_o(led_s)
  );
  // Straps are caught a few cycles after reset release, once the
  // synchronisers hold real pin levels; pins are not driven until then.
  logic [1:0] cap_cnt_r;
  logic strap_done_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      cap_cnt_r <= cap_cnt_r + 2'h1;
      strap_done_r <= (cap_cnt_r == 2'h3);
    end
  end
  wire strap_take = !strap_done_r && (cap_cnt_r == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] basic_mode_control_r;
  logic [15:0] indicator_direct_override_r;
  logic [15:0] transceiver_control_r;
  logic [15:0] diag_r;
  logic strap_iso_r;
  logic [2:0] led_pol_r;
  logic pass_r;
  logic [7:0] err_cnt_r;
  wire wr_basic_mode_control = reg_we_i && reg_addr_i == `PSLB_OFF_BASIC_MODE_CONTROL;
  wire wr_indicator_direct_override = reg_we_i && reg_addr_i == `PSLB_OFF_INDICATOR_DIRECT_OVERRIDE;
  wire wr_transceiver_control = reg_we_i && reg_addr_i == `PSLB_OFF_TRANSCEIVER_CONTROL;
  wire wr_diag = reg_we_i && reg_addr_i == `PSLB_OFF_DIAG;
  wire start_wr = wr_transceiver_control && reg_wdata_i[`PSLB_TRANSCEIVER_CONTROL_START];
  // Management is served regardless of isolate state.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      basic_mode_control_r <= `PSLB_BASIC_MODE_CONTROL_RST;
      indicator_direct_override_r <= `PSLB_INDICATOR_DIRECT_OVERRIDE_RST;
      transceiver_control_r <= 16'h0001;
      diag_r <= `PSLB_DIAG_RST;
      strap_iso_r <= 1'b0;
      led_pol_r <= 3'h0;
    end else begin
      if (strap_take) begin
        transceiver_control_r[4:0] <= strap_s;
        transceiver_control_r[`PSLB_TRANSCEIVER_CONTROL_MODE0] <= led_s[2];
        strap_iso_r <= (strap_s == 5'h00);
        led_pol_r <= led_s;
      end else if (wr_transceiver_control) begin
        transceiver_control_r <= reg_wdata_i;
      end
      if (wr_basic_mode_control) begin
        basic_mode_control_r <= reg_wdata_i;
      end
      if (wr_indicator_direct_override) begin
        indicator_direct_override_r <= reg_wdata_i;
      end
      if (wr_diag) begin
        diag_r <= reg_wdata_i;
      end
    end
  end
  wire isolate = strap_iso_r || basic_mode_control_r[`PSLB_BASIC_MODE_CONTROL_ISO];
  wire loopback = basic_mode_control_r[`PSLB_BASIC_MODE_CONTROL_LOOP];
  ////////////////////////////////////////////////////////////////////////////
  // Parallel detection cannot learn duplex, so it forces half duplex.
  wire eff_fd = full_duplex_i && !par_detect_i;
  logic [15:0] rd_mux;
  wire [15:0] sts_word = {12'h000, loopback, eff_fd, speed100_i,
                          link_good_i};
  wire [15:0] transceiver_control_rd = {transceiver_control_r[15:10], pass_r, transceiver_control_r[8:0]};
  wire [15:0] diag_rd = {err_cnt_r, diag_r[7:0]};
  always_comb begin
    case (reg_addr_i)
      `PSLB_OFF_BASIC_MODE_CONTROL: rd_mux = basic_mode_control_r;
      `PSLB_OFF_STS: rd_mux = sts_word;
      `PSLB_OFF_INDICATOR_DIRECT_OVERRIDE: rd_mux = indicator_direct_override_r;
      `PSLB_OFF_TRANSCEIVER_CONTROL: rd_mux = transceiver_control_rd;
      `PSLB_OFF_DIAG: rd_mux = diag_rd;
      default: rd_mux = 16'h0000;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Self test: transmit sequence and local reference for comparison.
  pslb_bist_st_t bst_r;
  logic [3:0] bist_tx;
  logic [3:0] bist_ref;
  logic [3:0] rx_nib;
  logic rx_valid;
  wire bist_on = bst_r != PSLB_ST_IDLE;
  wire seq_long = transceiver_control_r[`PSLB_TRANSCEIVER_CONTROL_SEQ15];
  wire cont = diag_r[`PSLB_DIAG_CONT];
  // Packet mode pauses on a short gap so the receiver sees frames.
  logic [6:0] pkt_cnt_r;
  wire bist_tx_en = bist_on && (cont || !pkt_cnt_r[6]);
  pslb_prbs u_tx_prbs (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .en_i(bist_tx_en),
    .long_i(seq_long),
    .load_i(start_wr),
    .seed_i(4'hF),
    .nib_o(bist_tx)
  );
  wire mis = bist_on && rx_valid && (rx_nib != bist_ref);
  pslb_prbs u_rx_prbs (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .en_i(bist_on && rx_valid),
    .long_i(seq_long),
    .load_i(start_wr),
    .seed_i(4'hF),
    .nib_o(bist_ref)
  );
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bst_r <= PSLB_ST_IDLE;
      pass_r <= 1'b0;
      err_cnt_r <= 8'h00;
      pkt_cnt_r <= 7'h00;
    end else begin
      pkt_cnt_r <= bist_on ? pkt_cnt_r + 7'h01 : 7'h00;
      case (bst_r)
        PSLB_ST_IDLE: begin
          if (start_wr) begin
            bst_r <= PSLB_ST_RUN;
            err_cnt_r <= 8'h00;
            pass_r <= 1'b0;
          end
        end
        PSLB_ST_RUN: begin
          if (start_wr) begin
            bst_r <= PSLB_ST_IDLE;
          end else if (mis) begin
            bst_r <= PSLB_ST_FAIL;
            pass_r <= 1'b0;
          end else if (rx_valid) begin
            pass_r <= 1'b1;
          end
        end
        PSLB_ST_FAIL: begin
          if (start_wr) begin
            bst_r <= PSLB_ST_IDLE;
          end
        end
        default: bst_r <= PSLB_ST_IDLE;
      endcase
      if (mis && err_cnt_r != 8'hFF) begin
        err_cnt_r <= err_cnt_r + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmit path: isolate drops packet data, loopback keeps it off line.
  wire tx_act = isolate ? 1'b0 : tx_en_i;
  wire [3:0] tx_src = bist_on ? bist_tx : txd_i;
  wire tx_req = bist_on ? bist_tx_en : tx_act;
  wire line_send = tx_req && !loopback && !isolate;
  assign rx_valid = loopback ? tx_req : line_rx_dv_i;
  assign rx_nib = loopback ? tx_src : line_rxd_i;
  wire rx_act = loopback ? tx_req : line_rx_act_i;
  wire col_raw = !eff_fd && line_col_i && !loopback;
  wire crs_raw = eff_fd ? rx_act : (rx_act || tx_req);
  ////////////////////////////////////////////////////////////////////////////
  // Blink divider for the link indicator, shared by modes 2 and 3.
  logic [23:0] blink_cnt_r;
  logic blink_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      blink_cnt_r <= 24'h000000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == `PSLB_BLINK_CYC) begin
      blink_cnt_r <= 24'h000000;
      blink_r <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 24'h000001;
    end
  end
  pslb_ind_mode_t mode;
  assign mode = transceiver_control_r[`PSLB_TRANSCEIVER_CONTROL_MODE0] ? PSLB_IND_M1 :
                transceiver_control_r[`PSLB_TRANSCEIVER_CONTROL_MODE1] ? PSLB_IND_M3 :
                PSLB_IND_M2;
  logic [2:0] ind;
  wire activity = rx_act || tx_req;
  always_comb begin
    ind[1] = speed100_i;
    case (mode)
      PSLB_IND_M1: begin
        ind[0] = link_good_i;
        ind[2] = activity;
      end
      PSLB_IND_M2: begin
        ind[0] = link_good_i && !(activity && blink_r);
        ind[2] = col_raw;
      end
      PSLB_IND_M3: begin
        ind[0] = link_good_i && !(activity && blink_r);
        ind[2] = eff_fd;
      end
      default: begin
        ind[0] = 1'b0;
        ind[2] = 1'b0;
      end
    endcase
  end
  // Override: bits [2:0] enable, bits [6:4] value per indicator.
  logic [2:0] ind_fin;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ind
      assign ind_fin[g] = (indicator_direct_override_r[g] ? indicator_direct_override_r[g+4] : ind[g])
                          ^ led_pol_r[g];
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
      rxd_o <= 4'h0;
      rxd_oe_o <= 4'h0;
      rx_dv_o <= 1'b0;
      col_o <= 1'b0;
      crs_o <= 1'b0;
      mii_oe_o <= 1'b0;
      col_oe_o <= 1'b0;
      line_tx_en_o <= 1'b0;
      line_txd_o <= 4'h0;
      line_eff_fd_o <= 1'b0;
      led_o <= 3'h0;
      led_oe_o <= 3'h0;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_mux : 16'h0000;
      rxd_o <= rx_nib;
      rxd_oe_o <= {4{strap_done_r && !isolate}};
      rx_dv_o <= rx_valid;
      col_o <= col_raw;
      crs_o <= crs_raw;
      mii_oe_o <= strap_done_r && !isolate;
      col_oe_o <= strap_done_r && !isolate;
      line_tx_en_o <= line_send;
      line_txd_o <= line_send ? tx_src : 4'h0;
      line_eff_fd_o <= eff_fd;
      led_o <= ind_fin;
      led_oe_o <= {3{strap_done_r}};
    end
  end
endmodule
`default_nettype wire

// File: verilog/pslb_consts.svh
// Offsets, field positions, reset values and counts for the strap/indicator/loopback/self-test block.
`ifndef PSLB_CONSTS_SVH
`define PSLB_CONSTS_SVH
`define PSLB_OFF_BASIC_MODE_CONTROL 5'h00
`define PSLB_OFF_STS 5'h10
`define PSLB_OFF_INDICATOR_DIRECT_OVERRIDE 5'h18
`define PSLB_OFF_TRANSCEIVER_CONTROL 5'h19
`define PSLB_OFF_DIAG 5'h1B
`define PSLB_BASIC_MODE_CONTROL_LOOP 14
`define PSLB_BASIC_MODE_CONTROL_AUTONEG 12
`define PSLB_BASIC_MODE_CONTROL_ISO 10
`define PSLB_STS_LOOP 3
`define PSLB_TRANSCEIVER_CONTROL_SEQ15 11
`define PSLB_TRANSCEIVER_CONTROL_START 10
`define PSLB_TRANSCEIVER_CONTROL_PASS 9
`define PSLB_TRANSCEIVER_CONTROL_MODE1 6
`define PSLB_TRANSCEIVER_CONTROL_MODE0 5
`define PSLB_DIAG_CONT 5
`define PSLB_BASIC_MODE_CONTROL_RST 16'h3000
`define PSLB_INDICATOR_DIRECT_OVERRIDE_RST 16'h0000
`define PSLB_DIAG_RST 16'h0000
`define PSLB_BLINK_CYC 24'h4C4B40
`define PSLB_DIAG_ERR_HI 15
`define PSLB_DIAG_ERR_LO 8
`endif

// File: verilog/pslb_pkg.sv
// Types shared by the strap/indicator/loopback/self-test block.
package pslb_pkg;
  typedef enum logic [2:0] {
    PSLB_IND_M1 = 3'b001,
    PSLB_IND_M2 = 3'b010,
    PSLB_IND_M3 = 3'b100
  } pslb_ind_mode_t;
  typedef enum logic [2:0] {
    PSLB_ST_IDLE = 3'b001,
    PSLB_ST_RUN = 3'b010,
    PSLB_ST_FAIL = 3'b100
  } pslb_bist_st_t;
endpackage

// File: verilog/pslb_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
`default_nettype none
module pslb_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: verilog/pslb_prbs.sv
// Pseudo-random nibble source with 9 or 15 bit sequence length.
`timescale 1ns/1ps
`default_nettype none
module pslb_prbs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic long_i,
  input wire logic load_i,
  input wire logic [3:0] seed_i,
  output logic [3:0] nib_o
);
  logic [14:0] lfsr_r;
  logic [14:0] lfsr_nxt;
  logic [3:0] nib;
  // Four serial steps per nibble; a zero state is avoided by the seeding.
  always_comb begin
    lfsr_nxt = lfsr_r;
    nib = 4'h0;
    for (int k = 0; k < 4; k++) begin
      nib[k] = long_i ? (lfsr_nxt[14] ^ lfsr_nxt[13])
                      : (lfsr_nxt[8] ^ lfsr_nxt[4]);
      lfsr_nxt = {lfsr_nxt[13:0], nib[k]};
    end
  end
  assign nib_o = nib;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lfsr_r <= 15'h7FFF;
    end else if (load_i) begin
      lfsr_r <= {11'h7FF, seed_i};
    end else if (en_i) begin
      lfsr_r <= lfsr_nxt;
    end
  end
endmodule
`default_nettype wire

// File: verification/pslb_chk_assertions.sv
// Port-level checker for the strap, indicator, loopback and self-test block.
`timescale 1ns/1ps
`default_nettype none
`include "pslb_consts.svh"
module pslb_chk (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic full_duplex_i,
  input wire logic par_detect_i,
  input wire logic line_rx_act_i,
  input wire logic line_col_i,
  input wire logic tx_en_i,
  input wire logic [3:0] rxd_oe_o,
  input wire logic mii_oe_o,
  input wire logic col_oe_o,
  input wire logic col_o,
  input wire logic crs_o,
  input wire logic line_tx_en_o,
  input wire logic line_eff_fd_o,
  input wire logic [2:0] led_oe_o
);
  logic loop_r;
  logic iso_r;
  wire fdc = full_duplex_i && !par_detect_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the mode bits, so the checks need no view inside the block.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      loop_r <= 1'b0;
      iso_r <= 1'b0;
    end else if (reg_we_i && reg_addr_i == `PSLB_OFF_BASIC_MODE_CONTROL) begin
      loop_r <= reg_wdata_i[`PSLB_BASIC_MODE_CONTROL_LOOP];
      iso_r <= reg_wdata_i[`PSLB_BASIC_MODE_CONTROL_ISO];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_rd_idle: assert property (
    !reg_re_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero while idle");
  a_iso_float: assert property (
    iso_r && $past(iso_r) |-> !mii_oe_o && !col_oe_o && rxd_oe_o == 4'h0)
    else $error("receive pins driven while isolated");
  a_iso_no_tx: assert property (
    iso_r [*2] |-> !line_tx_en_o)
    else $error("line sends data while isolated");
  a_loop_no_line: assert property (
    loop_r && $past(loop_r) |-> !line_tx_en_o)
    else $error("line sends data in loopback");
  a_fd_no_col: assert property (
    fdc [*3] |-> !col_o)
    else $error("collision reported in full duplex");
  a_fd_crs_rx: assert property (
    (fdc && !line_rx_act_i && !loop_r) [*3] |-> !crs_o)
    else $error("carrier without receive in full duplex");
  a_hd_crs_tx: assert property (
    (!fdc && tx_en_i && !iso_r && !loop_r) [*3] |-> crs_o)
    else $error("no carrier for transmit in half duplex");
  a_pd_half: assert property (
    par_detect_i && $past(par_detect_i) |-> !line_eff_fd_o)
    else $error("full duplex after parallel detection");
  a_led_up: assert property (
    $fell(srst_i) |-> ##[1:8] led_oe_o == 3'h7)
    else $error("strap capture never completed");
  a_led_hold: assert property (
    led_oe_o == 3'h7 |=> led_oe_o == 3'h7)
    else $error("indicator drive dropped");
  c_iso: cover property (iso_r [*2]);
  c_loop_tx: cover property (loop_r && tx_en_i);
  c_hd_col: cover property (!fdc && line_col_i && col_o);
endmodule
bind pslb_top pslb_chk i_chk (.*);
`default_nettype wire

// File: verification/pslb_board.sv
// Board model: strap resistors on the shared receive and indicator pins.
`timescale 1ns/1ps
`default_nettype none
module pslb_board (
  input wire logic strap_en_i,
  input wire logic [4:0] addr_i,
  input wire logic [2:0] led_strap_i,
  input wire logic [3:0] rxd_i,
  input wire logic [3:0] rxd_oe_i,
  input wire logic col_i,
  input wire logic col_oe_i,
  input wire logic [2:0] led_i,
  input wire logic [2:0] led_oe_i,
  output logic col_pin_o,
  output logic [3:0] rxd_pin_o,
  output logic [2:0] led_pin_o
);
  // Weak pulls alone give address 00001; a released pin falls to its strap.
  wire [4:0] addr = strap_en_i ? addr_i : 5'h01;
  assign col_pin_o = col_oe_i ? col_i : addr[0];
  assign rxd_pin_o = (rxd_oe_i & rxd_i) | (~rxd_oe_i & addr[4:1]);
  assign led_pin_o = (led_oe_i & led_i) | (~led_oe_i & led_strap_i);
endmodule
`default_nettype wire

// File: verification/tb_pslb_top.sv
// Testbench for the strap, indicator, loopback and self-test block.
`timescale 1ns/1ps
`default_nettype none
`include "pslb_consts.svh"
module tb_pslb_top;
  logic clock_i, srst_i, reg_we_i, reg_re_i, link_good_i, speed100_i;
  logic full_duplex_i, par_detect_i, line_rx_act_i, line_col_i;
  logic line_rx_dv_i, tx_en_i, col_pin_i, rx_dv_o, col_o, crs_o;
  logic mii_oe_o, col_oe_o, line_tx_en_o, line_eff_fd_o, s_en;
  logic [3:0] line_rxd_i, txd_i, rxd_pin_i, rxd_o, rxd_oe_o, line_txd_o;
  logic [2:0] led_pin_i, led_o, led_oe_o, s_led;
  logic [4:0] reg_addr_i, s_addr;
  logic [15:0] reg_wdata_i, reg_rdata_o, v;
  int n_mismatch = 0;
  int compares = 0;
  int n_cyc = 0;
  pslb_top i_dut (.*);
  pslb_board i_board (
    .strap_en_i(s_en), .addr_i(s_addr), .led_strap_i(s_led),
    .rxd_i(rxd_o), .rxd_oe_i(rxd_oe_o), .col_i(col_o),
    .col_oe_i(col_oe_o), .led_i(led_o), .led_oe_i(led_oe_o),
    .col_pin_o(col_pin_i), .rxd_pin_o(rxd_pin_i), .led_pin_o(led_pin_i)
  );
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The whole run needs about 1,600 cycles; a hang stops well after that.
  always @(posedge clock_i) begin
    n_cyc++;
    if (n_cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clock_i);
  endtask
  // Ends just after an edge so outputs are settled when compared.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] m,
                      input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask
  // Straps must stay put through capture, so they change only in reset.
  task automatic rst(input logic en, input logic [4:0] a);
    @(posedge clock_i);
    srst_i <= 1'b1;
    s_en <= en;
    s_addr <= a;
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (10) @(posedge clock_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1;
    {reg_we_i, reg_re_i, link_good_i, speed100_i, full_duplex_i} = '0;
    {par_detect_i, line_rx_act_i, line_col_i, line_rx_dv_i, tx_en_i} = '0;
    {reg_addr_i, reg_wdata_i, txd_i} = '0;
    line_rxd_i = 4'h5;
    s_en = 1'b1;
    s_addr = 5'h05;
    s_led = 3'b101;
    rst(1'b1, 5'h05);
    rchk(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h027F, 16'h0025);
    rchk(`PSLB_OFF_BASIC_MODE_CONTROL, 16'hFFFF, `PSLB_BASIC_MODE_CONTROL_RST);
    rchk(`PSLB_OFF_INDICATOR_DIRECT_OVERRIDE, 16'hFFFF, `PSLB_INDICATOR_DIRECT_OVERRIDE_RST);
    rchk(5'h0F, 16'hFFFF, 16'h0000);
    wr(`PSLB_OFF_INDICATOR_DIRECT_OVERRIDE, 16'h0077);
    rchk(`PSLB_OFF_INDICATOR_DIRECT_OVERRIDE, 16'hFFFF, 16'h0077);
    cyc(3);
    chk(16'({led_oe_o, led_o}), 16'h003A);
    wr(`PSLB_OFF_INDICATOR_DIRECT_OVERRIDE, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      tick();
      speed100_i <= i[0];
      link_good_i <= i[0];
      cyc(4);
      chk(16'(led_o[1:0]), 16'(2'b01 ^ {i[0], i[0]}));
    end
    wr(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0045);
    for (int i = 0; i < 2; i++) begin
      tick();
      full_duplex_i <= 1'b1;
      par_detect_i <= i[0];
      cyc(4);
      chk(16'({line_eff_fd_o, led_o[2]}), 16'({~i[0], i[0]}));
    end
    wr(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0005);
    for (int i = 0; i < 2; i++) begin
      tick();
      speed100_i <= 1'b0;
      par_detect_i <= 1'b0;
      line_col_i <= 1'b1;
      full_duplex_i <= i[0];
      cyc(4);
      chk(16'({col_o, led_o[2], led_o[0]}), 16'({~i[0], i[0], 1'b0}));
    end
    wr(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0000);
    cyc(3);
    chk(16'(mii_oe_o), 16'h0001);
    wr(`PSLB_OFF_BASIC_MODE_CONTROL, 16'h0400);
    tick();
    tx_en_i <= 1'b1;
    txd_i <= 4'hA;
    cyc(3);
    chk(16'({mii_oe_o, col_oe_o, rxd_oe_o, line_tx_en_o}), 16'h0000);
    rchk(`PSLB_OFF_BASIC_MODE_CONTROL, 16'hFFFF, 16'h0400);
    wr(`PSLB_OFF_BASIC_MODE_CONTROL, 16'h4000);
    rchk(`PSLB_OFF_STS, 16'h0008, 16'h0008);
    chk(16'({rx_dv_o, rxd_o, line_tx_en_o}), 16'h0034);
    wr(`PSLB_OFF_BASIC_MODE_CONTROL, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      tick();
      full_duplex_i <= i[0];
      line_col_i <= 1'b0;
      cyc(4);
      chk(16'({crs_o, line_tx_en_o, line_txd_o}), 16'({~i[0], 5'h1A}));
    end
    tick();
    tx_en_i <= 1'b0;
    wr(`PSLB_OFF_BASIC_MODE_CONTROL, 16'h4000);
    for (int i = 0; i < 2; i++) begin
      wr(`PSLB_OFF_TRANSCEIVER_CONTROL, {4'h0, i[0], 11'h400});
      cyc(400);
      rchk(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0200, 16'h0200);
      rchk(`PSLB_OFF_DIAG, 16'hFF00, 16'h0000);
      wr(`PSLB_OFF_TRANSCEIVER_CONTROL, {4'h0, i[0], 11'h400});
    end
    wr(`PSLB_OFF_DIAG, 16'h0020);
    rchk(`PSLB_OFF_DIAG, 16'h0020, 16'h0020);
    wr(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0400);
    cyc(400);
    rchk(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0200, 16'h0200);
    // Leaving loopback feeds a fixed nibble, which cannot match the sequence.
    wr(`PSLB_OFF_BASIC_MODE_CONTROL, 16'h0000);
    tick();
    line_rx_dv_i <= 1'b1;
    line_rx_act_i <= 1'b1;
    cyc(200);
    rchk(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h0200, 16'h0000);
    rd(`PSLB_OFF_DIAG, v);
    chk(16'(v[15:8] == 8'h00), 16'h0000);
    rst(1'b0, 5'h00);
    rchk(`PSLB_OFF_TRANSCEIVER_CONTROL, 16'h001F, 16'h0001);
    rst(1'b1, 5'h00);
    cyc(1);
    chk(16'({mii_oe_o, led_oe_o}), 16'h0007);
    stop_test();
  end
endmodule
`default_nettype wire
